// ---- hdl/cesr_pkg.sv ----
// Notes on behaviour
// (RQ1) A 23-entry byte-wide segment list names which registers move to and from NVM.
// (RQ2) The walker moves exactly the listed byte count from each listed start address.
// (RQ3) Opcode entries are recognised: commit to active registers, and end of data.
// (RQ4) The reset list covers every configuration register and ends with a commit.
// (RQ5) Transfer status reads 1 while a transfer runs and 0 once it is done.
// (RQ6) Transfer status also drives status pin zero when its routing bit is set.
// (RQ7) The error bit reads 1 when a transfer detected incorrect data, else 0.
// (RQ8) With boot-select low, writing reload soft-resets from NVM; the bit self-clears.
// (RQ9) Write enable resets to 0, blocking NVM writes; 1 lifts the protection.
// (RQ10) Writing store starts buffer-to-NVM copy; the controller clears it when done.
// (RQ11) Commit, by opcode or software, pulses the buffer-to-active copy, self-clearing; the code ignores the opcode during a store.
// (RQ12) A store while write protection is active leaves NVM contents unchanged.
package cesr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [11:0] A_ROUTE = 12'h232;
    localparam logic [11:0] A_UPDATE = 12'h234;
    localparam logic [11:0] A_SEG = 12'hA00;
    localparam logic [11:0] A_SEG_LAST = 12'hA16;
    localparam logic [11:0] A_STATUS = 12'hB00;
    localparam logic [11:0] A_ERROR = 12'hB01;
    localparam logic [11:0] A_CTRL1 = 12'hB02;
    localparam logic [11:0] A_CTRL2 = 12'hB03;
    localparam logic [11:0] A_IRQ_STATUS = 12'hB10;
    localparam logic [11:0] A_IRQ_CLEAR = 12'hB11;
    localparam logic [11:0] A_IRQ_ENABLE = 12'hB12;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int ROUTE_BIT = 4;
    localparam int UPDATE_BIT = 0;
    localparam int STATUS_BIT = 0;
    localparam int ERROR_BIT = 0;
    localparam int WREN_BIT = 0;
    localparam int RELOAD_BIT = 1;
    localparam int STORE_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int COUNT_FLAG_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Segment list layout and opcodes.
    localparam logic [4:0] SEG_COUNT = 5'h17;
    localparam logic [7:0] OP_COMMIT = 8'h80;
    localparam logic [7:0] OP_END = 8'hFF;

    // Default walk: 0x000 to 0x232 in five segments, then commit, then end.
    // Each segment is a count entry followed by address high and low entries.
    localparam logic [22:0][7:0] SEG_RESET = {
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, OP_COMMIT,
        8'hFC, 8'h01, 8'h37,
        8'h7D, 8'h01, 8'h7F,
        8'hFE, 8'h00, 8'h7F,
        8'h7F, 8'h00, 8'h7F,
        8'h00, 8'h00, 8'h7F
    };

    ////////////////////////////////////////////////////////////////////////////
    // Carriers and state.
    typedef enum logic [2:0] {
        ST_IDLE, ST_ENTRY, ST_READ, ST_WAIT, ST_WRITE,
        ST_SUM, ST_SUM_WAIT, ST_SUM_CHECK
    } cesr_fsm_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cesr_cfg_req_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } cesr_nvm_req_type;

endpackage

// ---- hdl/cesr_top.sv ----
`timescale 1ns/1ps
module cesr_top (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Device pins.
    input wire logic i_boot_sel,
    output logic o_status_pin_zero,
    output logic o_irq,
    // Buffer register bank.
    output cesr_pkg::cesr_cfg_req_type o_cfg,
    input wire logic [7:0] i_cfg_rdata,
    output logic o_commit,
    output logic o_soft_reset,
    // Nonvolatile array.
    output cesr_pkg::cesr_nvm_req_type o_nvm,
    input wire logic [7:0] i_nvm_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // State of the whole block in one record.
    typedef struct packed {
        logic [22:0][7:0] seg;
        logic route_en;
        logic wr_en;
        logic store_req;
        logic reload_req;
        logic busy;
        logic error;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic irq;
        logic pin;
        logic [7:0] rdata;
        logic dir_store;
        logic [4:0] idx;
        logic [6:0] cnt;
        logic [11:0] addr;
        logic [9:0] nptr;
        logic [7:0] sum;
        cesr_pkg::cesr_fsm_type fsm;
        cesr_pkg::cesr_cfg_req_type cfg;
        cesr_pkg::cesr_nvm_req_type nvm;
        logic commit;
        logic soft_reset;
    } cesr_state_type;

    cesr_state_type s;
    cesr_state_type next_s;
    logic [7:0] entry;
    logic [7:0] xfer_data;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers shared by the register port and the walker.
    function automatic logic [4:0] seg_index(input logic [11:0] addr);
        seg_index = 5'(addr - cesr_pkg::A_SEG);
    endfunction

    function automatic logic in_seg(input logic [11:0] addr);
        in_seg = (addr >= cesr_pkg::A_SEG) && (addr <= cesr_pkg::A_SEG_LAST);
    endfunction

    // Past the last slot the list reads as end of data, so a list without
    // a terminator still stops cleanly.
    function automatic logic [7:0] entry_at(input logic [22:0][7:0] seg,
                                            input logic [4:0] idx);
        if (idx < cesr_pkg::SEG_COUNT) begin
            entry_at = seg[idx];
        end else begin
            entry_at = cesr_pkg::OP_END;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        next_s = s;
        entry = entry_at(s.seg, s.idx);
        xfer_data = s.dir_store ? i_cfg_rdata : i_nvm_rdata;
        // The two address entries that follow a count entry.
        addr_hi = entry_at(s.seg, 5'(s.idx + 5'h01));
        addr_lo = entry_at(s.seg, 5'(s.idx + 5'h02));
        next_s.cfg.rd = 1'b0;
        next_s.cfg.wr = 1'b0;
        next_s.nvm.rd = 1'b0;
        next_s.nvm.wr = 1'b0;
        next_s.commit = 1'b0;
        next_s.soft_reset = 1'b0;
        next_s.rdata = 8'h00;

        // Register reads answer in the next cycle; reserved bits read zero.
        if (i_rd) begin
            if (in_seg(i_addr)) begin
                next_s.rdata = s.seg[seg_index(i_addr)];
            end else begin
                unique case (i_addr)
                    cesr_pkg::A_ROUTE: next_s.rdata[cesr_pkg::ROUTE_BIT] = s.route_en;
                    cesr_pkg::A_STATUS: next_s.rdata[cesr_pkg::STATUS_BIT] = s.busy; // [RQ5]
                    cesr_pkg::A_ERROR: next_s.rdata[cesr_pkg::ERROR_BIT] = s.error; // [RQ7]
                    cesr_pkg::A_CTRL1: begin
                        next_s.rdata[cesr_pkg::WREN_BIT] = s.wr_en;
                        next_s.rdata[cesr_pkg::RELOAD_BIT] = s.reload_req;
                    end
                    cesr_pkg::A_CTRL2: next_s.rdata[cesr_pkg::STORE_BIT] = s.store_req;
                    cesr_pkg::A_IRQ_STATUS: next_s.rdata[1:0] = s.irq_status;
                    cesr_pkg::A_IRQ_ENABLE: next_s.rdata[1:0] = s.irq_enable;
                    default: next_s.rdata = 8'h00;
                endcase
            end
        end

        // Register writes. Store and reload requests are ignored while busy,
        // since the walker owns the list pointer until it finishes.
        if (i_wr) begin
            if (in_seg(i_addr)) begin
                next_s.seg[seg_index(i_addr)] = i_wdata; // [RQ1]
            end else begin
                unique case (i_addr)
                    cesr_pkg::A_ROUTE: next_s.route_en = i_wdata[cesr_pkg::ROUTE_BIT];
                    cesr_pkg::A_UPDATE: begin
                        next_s.commit = i_wdata[cesr_pkg::UPDATE_BIT]; // [RQ11]
                    end
                    cesr_pkg::A_CTRL1: begin
                        next_s.wr_en = i_wdata[cesr_pkg::WREN_BIT]; // [RQ9]
                        if (i_wdata[cesr_pkg::RELOAD_BIT] && !i_boot_sel && !s.busy) begin
                            next_s.reload_req = 1'b1; // [RQ8]
                        end
                    end
                    cesr_pkg::A_CTRL2: begin
                        if (i_wdata[cesr_pkg::STORE_BIT] && !s.busy) begin
                            next_s.store_req = 1'b1; // [RQ10]
                        end
                    end
                    cesr_pkg::A_IRQ_CLEAR: next_s.irq_status = s.irq_status & ~i_wdata[1:0];
                    cesr_pkg::A_IRQ_ENABLE: next_s.irq_enable = i_wdata[1:0];
                    default: ;
                endcase
            end
        end

        // Segment walker. Each data byte takes three cycles: request, wait for the
        // one-cycle read latency, then write the far side; decode runs once per segment.
        unique case (s.fsm)
            cesr_pkg::ST_IDLE: begin
                next_s.idx = 5'h00;
                next_s.nptr = 10'h000;
                next_s.sum = 8'h00;
                if (s.store_req && !s.wr_en) begin
                    // Protected: finish at once without touching the array.
                    next_s.store_req = 1'b0; // [RQ12]
                    next_s.irq_status[cesr_pkg::IRQ_DONE_BIT] = 1'b1;
                end else if (s.store_req) begin
                    next_s.dir_store = 1'b1;
                    next_s.busy = 1'b1; // [RQ5]
                    next_s.error = 1'b0;
                    next_s.fsm = cesr_pkg::ST_ENTRY;
                end else if (s.reload_req) begin
                    next_s.reload_req = 1'b0; // [RQ8]
                    next_s.soft_reset = 1'b1;
                    next_s.dir_store = 1'b0;
                    next_s.busy = 1'b1;
                    next_s.error = 1'b0;
                    next_s.fsm = cesr_pkg::ST_ENTRY;
                end
            end
            cesr_pkg::ST_ENTRY: begin
                if (entry == cesr_pkg::OP_END) begin
                    next_s.fsm = cesr_pkg::ST_SUM; // [RQ3]
                end else if (entry == cesr_pkg::OP_COMMIT) begin
                    // Applying registers only makes sense when loading them.
                    // A software commit in the same cycle must not be lost.
                    next_s.commit = next_s.commit | !s.dir_store; // [RQ3] [RQ11]
                    next_s.idx = 5'(s.idx + 5'h01);
                end else if (!entry[cesr_pkg::COUNT_FLAG_BIT] && entry != 8'h00) begin
                    next_s.cnt = entry[6:0]; // [RQ2]
                    next_s.addr = {addr_hi[3:0], addr_lo};
                    next_s.idx = 5'(s.idx + 5'h03);
                    next_s.fsm = cesr_pkg::ST_READ;
                end else begin
                    // Unknown opcodes and zero counts are skipped.
                    next_s.idx = 5'(s.idx + 5'h01);
                end
            end
            cesr_pkg::ST_READ: begin
                next_s.cfg.rd = s.dir_store;
                next_s.cfg.addr = s.addr;
                next_s.nvm.rd = !s.dir_store;
                next_s.nvm.addr = s.nptr;
                next_s.fsm = cesr_pkg::ST_WAIT;
            end
            cesr_pkg::ST_WAIT: next_s.fsm = cesr_pkg::ST_WRITE;
            cesr_pkg::ST_WRITE: begin
                next_s.nvm.wr = s.dir_store && s.wr_en; // [RQ9]
                next_s.nvm.addr = s.nptr;
                next_s.nvm.wdata = xfer_data;
                next_s.cfg.wr = !s.dir_store;
                next_s.cfg.addr = s.addr;
                next_s.cfg.wdata = xfer_data;
                next_s.sum = s.sum ^ xfer_data;
                next_s.nptr = 10'(s.nptr + 10'h001);
                next_s.addr = 12'(s.addr + 12'h001);
                next_s.cnt = 7'(s.cnt - 7'h01);
                next_s.fsm = (s.cnt == 7'h01) ? cesr_pkg::ST_ENTRY : cesr_pkg::ST_READ; // [RQ2]
            end
            cesr_pkg::ST_SUM: begin
                // Storing appends the check byte and reads it back; loading reads it.
                next_s.nvm.wr = s.dir_store && s.wr_en;
                next_s.nvm.addr = s.nptr;
                next_s.nvm.wdata = s.sum;
                next_s.fsm = cesr_pkg::ST_SUM_WAIT;
            end
            cesr_pkg::ST_SUM_WAIT: begin
                next_s.nvm.rd = 1'b1;
                next_s.nvm.addr = s.nptr;
                next_s.fsm = cesr_pkg::ST_SUM_CHECK;
            end
            cesr_pkg::ST_SUM_CHECK: begin
                // The read issued last cycle is on the port now; its data returns a cycle later.
                if (s.nvm.rd) begin
                    next_s.fsm = cesr_pkg::ST_SUM_CHECK;
                end else begin
                    next_s.error = (i_nvm_rdata != s.sum); // [RQ7]
                    // Built on the next value so a clear in this cycle still lands
                    // when no new error is seen; a new error wins over the clear.
                    next_s.irq_status[cesr_pkg::IRQ_ERR_BIT] =
                        next_s.irq_status[cesr_pkg::IRQ_ERR_BIT] | (i_nvm_rdata != s.sum);
                    next_s.irq_status[cesr_pkg::IRQ_DONE_BIT] = 1'b1;
                    next_s.busy = 1'b0; // [RQ5]
                    next_s.store_req = 1'b0; // [RQ10]
                    next_s.fsm = cesr_pkg::ST_IDLE;
                end
            end
        endcase

        // Outputs are computed from the next state so that each leaves a flop.
        next_s.pin = next_s.route_en & next_s.busy; // [RQ6]
        next_s.irq = |(next_s.irq_status & next_s.irq_enable);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
            s.seg <= cesr_pkg::SEG_RESET; // [RQ4]
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ports straight from the state flops.
    assign o_rdata = s.rdata;
    assign o_status_pin_zero = s.pin;
    assign o_irq = s.irq;
    assign o_cfg = s.cfg;
    assign o_commit = s.commit;
    assign o_soft_reset = s.soft_reset;
    assign o_nvm = s.nvm;

endmodule

// ---- tb/cesr_checker.sv ----
`timescale 1ns/1ps
module cesr_checker (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Pins and requests.
    input wire logic o_status_pin_zero,
    input wire logic o_irq,
    input wire cesr_pkg::cesr_cfg_req_type o_cfg,
    input wire logic o_commit,
    input wire logic o_soft_reset,
    input wire cesr_pkg::cesr_nvm_req_type o_nvm
);
    ////////////////////////////////////////////////////////////
    // Shadows of write enable and routing, since the checker cannot see inside.
    logic wren_q;
    logic route_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wren_q <= 1'b0;
            route_q <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == cesr_pkg::A_CTRL1) wren_q <= i_wdata[0];
            if (i_addr == cesr_pkg::A_ROUTE) route_q <= i_wdata[4];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Read data shows only in the answer cycle; reserved bits of the error register read zero.
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    a_error_rsvd: assert property (i_rd && i_addr == cesr_pkg::A_ERROR |=> o_rdata[7:1] == 7'h00)
        else $error("error register upper bits set");
    // Commit is a self-clearing one-cycle pulse, also on a software request.
    a_commit_soft: assert property (i_wr && i_addr == cesr_pkg::A_UPDATE && i_wdata[0] |=> o_commit)
        else $error("software commit gave no pulse");
    a_commit_clear: assert property (o_commit |=> !o_commit)
        else $error("commit held longer than one cycle");
    a_soft_once: assert property (o_soft_reset |=> !o_soft_reset)
        else $error("soft reset held longer than one cycle");
    // No array write may happen while protection is on.
    a_nvm_protect: assert property (o_nvm.wr |-> wren_q)
        else $error("array written while protected");
    // The pin follows busy when routed and stays low when not.
    a_pin_follow: assert property ((o_nvm.wr || o_nvm.rd || o_cfg.rd || o_cfg.wr)
        && route_q && $past(route_q) |-> o_status_pin_zero)
        else $error("status pin low during a transfer");
    a_pin_gated: assert property (!route_q && !$past(route_q) |-> !o_status_pin_zero)
        else $error("status pin high while not routed");
    c_store: cover property (o_nvm.wr);
    c_reload: cover property (o_soft_reset);
    c_irq: cover property (o_irq);
endmodule

// ---- tb/cesr_nvm_model.sv ----
`timescale 1ns/1ps
module cesr_nvm_model (
    // Clock.
    input wire logic i_clk,
    // Request and a fault switch that inverts read data.
    input wire cesr_pkg::cesr_nvm_req_type i_nvm,
    input wire logic i_corrupt,
    // Read data.
    output logic [7:0] o_rdata
);
    ////////////////////////////////////////////////////////////
    logic [7:0] mem [1024];
    initial o_rdata = 8'h00;
    // Reads answer a cycle later; between reads the lines toggle, so a held value cannot pass.
    always @(posedge i_clk) begin
        if (i_nvm.wr) mem[i_nvm.addr] <= i_nvm.wdata;
        if (i_nvm.rd) o_rdata <= i_corrupt ? ~mem[i_nvm.addr] : mem[i_nvm.addr];
        else o_rdata <= ~o_rdata;
    end
endmodule

// ---- tb/cesr_top_tb.sv ----
`timescale 1ns/1ps
module cesr_top_tb;
    ////////////////////////////////////////////////////////////
    logic i_clk, i_rst_b, i_wr, i_rd, i_boot_sel, corrupt;
    logic [11:0] i_addr;
    logic [7:0] i_wdata, o_rdata, i_cfg_rdata, i_nvm_rdata, rv;
    logic o_status_pin_zero, o_irq, o_commit, o_soft_reset;
    cesr_pkg::cesr_cfg_req_type o_cfg;
    cesr_pkg::cesr_nvm_req_type o_nvm;
    int fail_count, cmp_count, n_commit, n_reset;
    logic [19:0] nvm_w[$], cfg_w[$];
    logic [11:0] ea [3] = '{12'h120, 12'h121, 12'h005};
    logic [7:0] lst [8] = '{8'h02, 8'h01, 8'h20, 8'h80, 8'h01, 8'h00, 8'h05, 8'hFF};
    cesr_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_boot_sel(i_boot_sel),
        .o_status_pin_zero(o_status_pin_zero), .o_irq(o_irq), .o_cfg(o_cfg),
        .i_cfg_rdata(i_cfg_rdata), .o_commit(o_commit), .o_soft_reset(o_soft_reset),
        .o_nvm(o_nvm), .i_nvm_rdata(i_nvm_rdata));
    cesr_nvm_model nvm (.i_clk(i_clk), .i_nvm(o_nvm), .i_corrupt(corrupt), .o_rdata(i_nvm_rdata));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // Pattern of the buffer bank: each register holds its low address byte mixed.
    function automatic logic [7:0] f(input logic [11:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    // Buffer bank answers a cycle after a read and toggles otherwise.
    always @(posedge i_clk) i_cfg_rdata <= o_cfg.rd ? f(o_cfg.addr) : ~i_cfg_rdata;
    // Log at the falling edge, where the design outputs have settled.
    always @(negedge i_clk) begin
        if (o_nvm.wr) nvm_w.push_back({2'b00, o_nvm.addr, o_nvm.wdata});
        if (o_cfg.wr) cfg_w.push_back({o_cfg.addr, o_cfg.wdata});
        if (o_commit) n_commit++;
        if (o_soft_reset) n_reset++;
    end
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        rd(a);
        chk(20'(rv), 20'(exp));
    endtask
    // Polls a self-clearing bit; the bound keeps a stuck bit from hanging the run.
    task automatic wait_clr(input logic [11:0] a, input int b);
        rv = 8'hFF;
        for (int k = 0; k < 3000 && rv[b] !== 1'b0; k++) rd(a);
        chk(20'(rv[b]), 20'd0);
    endtask
    task automatic store(input logic bad);
        corrupt = bad;
        nvm_w.delete();
        wr(cesr_pkg::A_IRQ_CLEAR, 8'h03);
        wr(cesr_pkg::A_CTRL2, 8'h01);
        @(posedge i_clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
    // Main sequence.
    initial begin
        {i_rst_b, i_wr, i_rd, i_boot_sel, corrupt, i_addr, i_wdata} = '0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 23; i++) rdc(cesr_pkg::A_SEG + 12'(i), cesr_pkg::SEG_RESET[i]);
        for (int i = 0; i < 4; i++) rdc(cesr_pkg::A_STATUS + 12'(i), 8'h00);
        wr(12'hC00, 8'h5A);
        rdc(12'hC00, 8'h00);
        $display("test defaults done");
        wr(cesr_pkg::A_IRQ_ENABLE, 8'h03);
        store(1'b0);
        wait_clr(cesr_pkg::A_CTRL2, 0);
        chk(20'(nvm_w.size()), 20'd0);
        rdc(cesr_pkg::A_IRQ_STATUS, 8'h01);
        chk(20'(o_irq), 20'd1);
        $display("test protected store done");
        for (int i = 0; i < 8; i++) wr(cesr_pkg::A_SEG + 12'(i), lst[i]);
        wr(cesr_pkg::A_CTRL1, 8'h01);
        wr(cesr_pkg::A_ROUTE, 8'h10);
        rdc(cesr_pkg::A_SEG + 12'h003, cesr_pkg::OP_COMMIT);
        rdc(cesr_pkg::A_ROUTE, 8'h10);
        store(1'b0);
        rdc(cesr_pkg::A_IRQ_STATUS, 8'h00);
        chk(20'(o_irq), 20'd0);
        rdc(cesr_pkg::A_STATUS, 8'h01);
        chk(20'(o_status_pin_zero), 20'd1);
        wait_clr(cesr_pkg::A_CTRL2, 0);
        chk(20'(nvm_w.size()), 20'd4);
        for (int k = 0; k < 3; k++) chk(nvm_w[k], {10'(k), f(ea[k])});
        chk(nvm_w[3], {10'd3, f(ea[0]) ^ f(ea[1]) ^ f(ea[2])});
        chk(20'(n_commit), 20'd0);
        rdc(cesr_pkg::A_STATUS, 8'h00);
        chk(20'(o_status_pin_zero), 20'd0);
        rdc(cesr_pkg::A_ERROR, 8'h00);
        $display("test store done");
        store(1'b1);
        wait_clr(cesr_pkg::A_CTRL2, 0);
        rdc(cesr_pkg::A_ERROR, 8'h01);
        rdc(cesr_pkg::A_IRQ_STATUS, 8'h03);
        corrupt = 1'b0;
        $display("test error done");
        @(posedge i_clk);
        i_boot_sel <= 1'b1;
        wr(cesr_pkg::A_CTRL1, 8'h03);
        repeat (20) @(posedge i_clk);
        chk(20'(n_reset), 20'd0);
        i_boot_sel <= 1'b0;
        wr(cesr_pkg::A_CTRL1, 8'h03);
        wait_clr(cesr_pkg::A_CTRL1, 1);
        wait_clr(cesr_pkg::A_STATUS, 0);
        chk(20'(n_reset), 20'd1);
        chk(20'(n_commit), 20'd1);
        chk(20'(cfg_w.size()), 20'd3);
        for (int k = 0; k < 3; k++) chk(cfg_w[k], {ea[k], f(ea[k])});
        rdc(cesr_pkg::A_ERROR, 8'h00);
        wr(cesr_pkg::A_UPDATE, 8'h01);
        @(posedge i_clk);
        chk(20'(n_commit), 20'd2);
        $display("test reload done");
        complete_run();
    end
endmodule
bind cesr_top cesr_checker chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_status_pin_zero(o_status_pin_zero), .o_irq(o_irq), .o_cfg(o_cfg),
    .o_commit(o_commit), .o_soft_reset(o_soft_reset), .o_nvm(o_nvm));
